// *** hdl/rcdt_pkg.sv ***
// shared constants for the countdown timer block
package rcdt_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] ADDR_FLAGS = 8'h0f;   // flags, read clears the expiry flag
    localparam logic [7:0] ADDR_VALUE = 8'h10;   // countdown reload / current value
    localparam logic [7:0] ADDR_CTRL = 8'h11;    // timer control

    // flags register field
    localparam int FLAG_EXPIRY_BIT = 3;

    // control register fields
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_PULSE_BIT = 6;
    localparam int CTRL_IRQ_EN_BIT = 5;
    localparam int CTRL_SEL_HI_BIT = 1;
    localparam int CTRL_SEL_LO_BIT = 0;

    // control and value reset values
    localparam logic RST_RUN = 1'b0;
    localparam logic RST_PULSE = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic [1:0] RST_SEL = 2'h3;
    localparam logic [7:0] RST_VALUE = 8'h00;

    // source clock select codes
    typedef enum logic [1:0] {
        SEL_4096HZ = 2'b00,
        SEL_64HZ = 2'b01,
        SEL_1HZ = 2'b10,
        SEL_MINUTE = 2'b11
    } rcdt_sel_e;

    // oscillator prescaler: 32768 Hz ticks
    localparam int OSC_HZ = 32768;
    localparam int PRESCALE_W = 15;
    localparam logic [14:0] DIV_4096_MASK = 15'h0007;  // every 8 oscillator ticks
    localparam logic [14:0] DIV_64_MASK = 15'h01ff;    // every 512 oscillator ticks
    localparam logic [14:0] DIV_1_MASK = 15'h7fff;     // every 32768 oscillator ticks
    localparam logic [5:0] SECONDS_PER_MINUTE_M1 = 6'h3b;

    // pulse widths in oscillator ticks, from fractions of a second
    localparam int PULSE_DEN_SHORT4K = 8192;
    localparam int PULSE_DEN_LONG4K = 4096;
    localparam int PULSE_DEN_SHORT64 = 128;
    localparam int PULSE_DEN_LONG = 64;
    localparam logic [9:0] PULSE_TICKS_SHORT4K = 10'(OSC_HZ / PULSE_DEN_SHORT4K);
    localparam logic [9:0] PULSE_TICKS_LONG4K = 10'(OSC_HZ / PULSE_DEN_LONG4K);
    localparam logic [9:0] PULSE_TICKS_SHORT64 = 10'(OSC_HZ / PULSE_DEN_SHORT64);
    localparam logic [9:0] PULSE_TICKS_LONG = 10'(OSC_HZ / PULSE_DEN_LONG);
endpackage : rcdt_pkg

// *** hdl/rcdt_timer.sv ***
// How it works
// - pulse starts with flag, width by source and reload
// - zero reload value keeps timer stopped
// - countdown end sets expiry flag
// - auto reload regardless of flag, mode
// - flags register read clears expiry flag
// - expiry flag has its own flags bit
// - level mode: output follows flag and enable
// - level released only clearing flag or enable
// - run enable zero halts countdown, no events
// - power loss clears run enable
// - re-enable resumes from held count
// - select: 4096, 64, 1 Hz, 1/60 Hz
// - period is reload over source frequency
// - eight-bit value register holds reload
// - value write keeps flag and interrupt
// - pulse select: pulses or steady level
// - pulse mode stops on run/enable/select clear
// - control bits live at control register
`timescale 1ns/1ns
module rcdt_timer (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // oscillator and power monitor
    input wire logic OSC_TICK,
    input wire logic POWER_FAIL,
    // internal register port from the serial engine
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // open-drain shared interrupt pin, active low
    output logic SHARED_INTERRUPT_OUTPUT_O,
    output logic SHARED_INTERRUPT_OUTPUT_OE_N,
    // status
    output logic TIMER_EXPIRY_FLAG
);
    // control bits
    logic timer_run_enable_q;
    logic irq_pulse_select_q;
    logic timer_irq_enable_q;
    logic timer_clock_select_hi_q;
    logic timer_clock_select_lo_q;
    logic [1:0] sel;
    // counter state
    logic [7:0] reload_q;   // programmed reload value
    logic [7:0] count_q;    // current countdown value
    logic timer_expiry_flag_q;
    // oscillator prescaler
    logic [14:0] prescale_q;
    logic [5:0] seconds_q;
    logic src_tick;
    logic expire;
    // pulse generator
    logic [9:0] pulse_cnt_q;
    logic [9:0] pulse_len;
    logic pulse_allowed;
    logic irq_q;
    logic rd_flags;
    logic wr_ctrl;
    logic wr_value;
    // control bits as they stand after this edge
    logic timer_run_enable_d;
    logic irq_pulse_select_d;
    logic timer_irq_enable_d;

    assign sel = {timer_clock_select_hi_q, timer_clock_select_lo_q};
    assign rd_flags = REG_RD && (REG_ADDR == rcdt_pkg::ADDR_FLAGS);
    assign wr_ctrl = REG_WR && (REG_ADDR == rcdt_pkg::ADDR_CTRL);
    assign wr_value = REG_WR && (REG_ADDR == rcdt_pkg::ADDR_VALUE);

    // next control values, so the pin answers on the edge of the write itself
    // rather than one clock after the register has moved
    assign timer_run_enable_d = POWER_FAIL ? 1'b0
        : (wr_ctrl ? REG_WDATA[rcdt_pkg::CTRL_RUN_BIT] : timer_run_enable_q);
    assign irq_pulse_select_d = wr_ctrl ? REG_WDATA[rcdt_pkg::CTRL_PULSE_BIT] : irq_pulse_select_q;
    assign timer_irq_enable_d = wr_ctrl ? REG_WDATA[rcdt_pkg::CTRL_IRQ_EN_BIT] : timer_irq_enable_q;

    // free-running divider of oscillator ticks
    always_ff @(posedge CLK) begin
        if (RST) begin
            prescale_q <= '0;
        end else if (OSC_TICK) begin
            prescale_q <= prescale_q + 15'h0001;
        end
    end

    // minute counter stepped once per second
    always_ff @(posedge CLK) begin
        if (RST) begin
            seconds_q <= '0;
        end else if (OSC_TICK && ((prescale_q & rcdt_pkg::DIV_1_MASK) == rcdt_pkg::DIV_1_MASK)) begin
            // wraps after sixty seconds
            seconds_q <= (seconds_q == rcdt_pkg::SECONDS_PER_MINUTE_M1) ? 6'h00 : seconds_q + 6'h01;
        end
    end

    // pick the countdown source tick
    always_comb begin
        unique case (rcdt_pkg::rcdt_sel_e'(sel))
            rcdt_pkg::SEL_4096HZ: begin
                src_tick = OSC_TICK && ((prescale_q & rcdt_pkg::DIV_4096_MASK) == rcdt_pkg::DIV_4096_MASK);
            end
            rcdt_pkg::SEL_64HZ: begin
                src_tick = OSC_TICK && ((prescale_q & rcdt_pkg::DIV_64_MASK) == rcdt_pkg::DIV_64_MASK);
            end
            rcdt_pkg::SEL_1HZ: begin
                src_tick = OSC_TICK && (prescale_q == rcdt_pkg::DIV_1_MASK);
            end
            rcdt_pkg::SEL_MINUTE: begin
                src_tick = OSC_TICK && (prescale_q == rcdt_pkg::DIV_1_MASK)
                    && (seconds_q == rcdt_pkg::SECONDS_PER_MINUTE_M1);
            end
        endcase
    end

    // terminal count: only when running with a nonzero reload
    assign expire = src_tick && timer_run_enable_q && (reload_q != 8'h00) && (count_q <= 8'h01);

    // control register; power loss forces the run bit off
    always_ff @(posedge CLK) begin
        if (RST) begin
            timer_run_enable_q <= rcdt_pkg::RST_RUN;
            irq_pulse_select_q <= rcdt_pkg::RST_PULSE;
            timer_irq_enable_q <= rcdt_pkg::RST_IRQ_EN;
            timer_clock_select_hi_q <= rcdt_pkg::RST_SEL[1];
            timer_clock_select_lo_q <= rcdt_pkg::RST_SEL[0];
        end else begin
            if (wr_ctrl) begin
                // all control bits share one register
                timer_run_enable_q <= REG_WDATA[rcdt_pkg::CTRL_RUN_BIT];
                irq_pulse_select_q <= REG_WDATA[rcdt_pkg::CTRL_PULSE_BIT];
                timer_irq_enable_q <= REG_WDATA[rcdt_pkg::CTRL_IRQ_EN_BIT];
                timer_clock_select_hi_q <= REG_WDATA[rcdt_pkg::CTRL_SEL_HI_BIT];
                timer_clock_select_lo_q <= REG_WDATA[rcdt_pkg::CTRL_SEL_LO_BIT];
            end
            if (POWER_FAIL) begin
                // power loss wins over a host write in the same cycle
                timer_run_enable_q <= 1'b0;
            end
        end
    end

    // reload value register
    always_ff @(posedge CLK) begin
        if (RST) begin
            reload_q <= rcdt_pkg::RST_VALUE;
        end else if (wr_value) begin
            reload_q <= REG_WDATA;
        end
    end

    // countdown; a disabled timer simply holds its count
    always_ff @(posedge CLK) begin
        if (RST) begin
            count_q <= rcdt_pkg::RST_VALUE;
        end else if (wr_value) begin
            // a fresh value restarts the count from it
            count_q <= REG_WDATA;
        end else if (expire) begin
            count_q <= reload_q;
        end else if (src_tick && timer_run_enable_q && (reload_q != 8'h00)) begin
            // nothing here when halted, so re-enable resumes
            count_q <= count_q - 8'h01;
        end
    end

    // expiry flag: set beats a clearing read in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            timer_expiry_flag_q <= 1'b0;
        end else if (expire) begin
            timer_expiry_flag_q <= 1'b1;
        end else if (rd_flags) begin
            timer_expiry_flag_q <= 1'b0;
        end
        // value writes never touch the flag
    end

    // pulse width in oscillator ticks from source and reload
    always_comb begin
        unique case (rcdt_pkg::rcdt_sel_e'(sel))
            rcdt_pkg::SEL_4096HZ: begin
                pulse_len = (reload_q == 8'h01) ? rcdt_pkg::PULSE_TICKS_SHORT4K : rcdt_pkg::PULSE_TICKS_LONG4K;
            end
            rcdt_pkg::SEL_64HZ: begin
                pulse_len = (reload_q == 8'h01) ? rcdt_pkg::PULSE_TICKS_SHORT64 : rcdt_pkg::PULSE_TICKS_LONG;
            end
            rcdt_pkg::SEL_1HZ, rcdt_pkg::SEL_MINUTE: begin
                pulse_len = rcdt_pkg::PULSE_TICKS_LONG;
            end
        endcase
    end

    // pulses live only while run, enable and pulse select are all set
    assign pulse_allowed = timer_run_enable_d && timer_irq_enable_d && irq_pulse_select_d;

    // pulse length counter, counts oscillator ticks
    always_ff @(posedge CLK) begin
        if (RST) begin
            pulse_cnt_q <= '0;
        end else if (!pulse_allowed) begin
            pulse_cnt_q <= '0;
        end else if (expire) begin
            // restarts every period, independent of the flag
            pulse_cnt_q <= pulse_len;
        end else if (OSC_TICK && (pulse_cnt_q != 10'h000)) begin
            pulse_cnt_q <= pulse_cnt_q - 10'h001;
        end
    end

    // interrupt level, registered so it rises on the flag's own edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else if (irq_pulse_select_d) begin
            if (!pulse_allowed) begin
                irq_q <= 1'b0;
            end else if (expire) begin
                irq_q <= 1'b1;
            end else if (OSC_TICK && (pulse_cnt_q <= 10'h001)) begin
                irq_q <= 1'b0;
            end
        end else begin
            // level mode: follows next flag value gated by enable
            irq_q <= timer_irq_enable_d && (expire || (timer_expiry_flag_q && !rd_flags));
        end
    end

    // open-drain pin: drives low, enable low while driving
    assign SHARED_INTERRUPT_OUTPUT_O = 1'b0;
    assign SHARED_INTERRUPT_OUTPUT_OE_N = !irq_q;
    assign TIMER_EXPIRY_FLAG = timer_expiry_flag_q;

    // register read data, unmapped reads as zero
    always_comb begin
        REG_RDATA = 8'h00;
        if (REG_ADDR == rcdt_pkg::ADDR_FLAGS) begin
            // only the timer bit is held here, alarm bits live elsewhere
            REG_RDATA[rcdt_pkg::FLAG_EXPIRY_BIT] = timer_expiry_flag_q;
        end else if (REG_ADDR == rcdt_pkg::ADDR_VALUE) begin
            REG_RDATA = count_q;
        end else if (REG_ADDR == rcdt_pkg::ADDR_CTRL) begin
            REG_RDATA[rcdt_pkg::CTRL_RUN_BIT] = timer_run_enable_q;
            REG_RDATA[rcdt_pkg::CTRL_PULSE_BIT] = irq_pulse_select_q;
            REG_RDATA[rcdt_pkg::CTRL_IRQ_EN_BIT] = timer_irq_enable_q;
            REG_RDATA[rcdt_pkg::CTRL_SEL_HI_BIT] = timer_clock_select_hi_q;
            REG_RDATA[rcdt_pkg::CTRL_SEL_LO_BIT] = timer_clock_select_lo_q;
        end
    end
endmodule : rcdt_timer

// *** verif/rcdt_timer_asserts.sv ***
`timescale 1ns/1ns
// ties flag and pin moves to their causes at the ports
module rcdt_timer_asserts (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // stimulus
    input wire logic OSC_TICK,
    input wire logic POWER_FAIL,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    // outputs
    input wire logic [7:0] REG_RDATA,
    input wire logic SHARED_INTERRUPT_OUTPUT_O,
    input wire logic SHARED_INTERRUPT_OUTPUT_OE_N,
    input wire logic TIMER_EXPIRY_FLAG
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // a control write not overruled by power loss
    sequence s_ctrl_wr;
        REG_WR && REG_ADDR == rcdt_pkg::ADDR_CTRL && !POWER_FAIL;
    endsequence
    // flags read with no expiry racing it
    sequence s_flag_rd;
        REG_RD && REG_ADDR == rcdt_pkg::ADDR_FLAGS && !OSC_TICK;
    endsequence
    property p_rd_clear;
        s_flag_rd |=> !TIMER_EXPIRY_FLAG;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flag survived a flags read");
    property p_flag_rise;
        $rose(TIMER_EXPIRY_FLAG) |-> $past(OSC_TICK);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without a source tick");
    property p_flag_hold;
        TIMER_EXPIRY_FLAG && !(REG_RD && REG_ADDR == rcdt_pkg::ADDR_FLAGS) |=> TIMER_EXPIRY_FLAG;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a read");
    property p_wr_keep;
        REG_WR && REG_ADDR == rcdt_pkg::ADDR_VALUE && TIMER_EXPIRY_FLAG |=> TIMER_EXPIRY_FLAG;
    endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("value write cleared the flag");
    property p_pf;
        POWER_FAIL |-> ##2 !$rose(TIMER_EXPIRY_FLAG);
    endproperty
    a_pf: assert property (p_pf) else $error("expiry after power loss");
    property p_fall;
        $fell(SHARED_INTERRUPT_OUTPUT_OE_N) |-> TIMER_EXPIRY_FLAG && ($past(OSC_TICK) || $past(REG_WR));
    endproperty
    a_fall: assert property (p_fall) else $error("pin asserted without flag");
    property p_rise;
        $rose(SHARED_INTERRUPT_OUTPUT_OE_N) |-> $past(REG_WR) || $past(REG_RD) || $past(OSC_TICK) || $past(POWER_FAIL);
    endproperty
    a_rise: assert property (p_rise) else $error("pin released without cause");
    // bits 4..2 are reserved, so they stay out of the compare
    property p_ctrl_rb;
        s_ctrl_wr ##1 REG_ADDR == rcdt_pkg::ADDR_CTRL |-> (REG_RDATA & 8'he3) == ($past(REG_WDATA) & 8'he3);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
endmodule : rcdt_timer_asserts

bind rcdt_timer rcdt_timer_asserts chk_u (.CLK(CLK), .RST(RST), .OSC_TICK(OSC_TICK), .POWER_FAIL(POWER_FAIL),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SHARED_INTERRUPT_OUTPUT_O(SHARED_INTERRUPT_OUTPUT_O), .SHARED_INTERRUPT_OUTPUT_OE_N(SHARED_INTERRUPT_OUTPUT_OE_N),
    .TIMER_EXPIRY_FLAG(TIMER_EXPIRY_FLAG));

// *** verif/rcdt_host_model.sv ***
`timescale 1ns/1ns
// host on the register port, plus the pull-up on the shared pin
module rcdt_host_model (
    // clock
    input wire logic clk,
    // register requests
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // open-drain halves and resolved wire
    input wire logic pin_o,
    input wire logic pin_oe_n,
    output logic irq_line_n
);
    // pull-up wins when nobody sinks the line
    assign irq_line_n = pin_oe_n ? 1'b1 : pin_o;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // strobe held to its taking edge; data inverted after release
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // read data taken at the edge that takes the strobe, before it updates
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        d = reg_rdata;
        reg_rd <= 1'b0;
    endtask : rd
endmodule : rcdt_host_model

// *** verif/rcdt_timer_tb.sv ***
`timescale 1ns/1ns
// register-level run through the countdown timer
module rcdt_timer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc_tick = 1'b0;
    logic power_fail = 1'b0;
    logic reg_wr, reg_rd, pin_o, pin_oe_n, flag, irq_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    // pulse table: reload, control, width and period in clocks
    logic [7:0] tn [4] = '{8'h01, 8'h03, 8'h01, 8'h02};
    logic [7:0] tc [4] = '{8'he0, 8'he0, 8'he1, 8'he1};
    logic [15:0] tw [4] = '{16'd8, 16'd16, 16'd512, 16'd1024};
    logic [15:0] tp [4] = '{16'd16, 16'd48, 16'd1024, 16'd2048};
    always #25 clk = ~clk;
    // oscillator tick every other clock keeps runs short
    always @(posedge clk) begin
        osc_tick <= ~osc_tick;
        cyc <= cyc + 1;
    end
    rcdt_timer dut_u (.CLK(clk), .RST(rst), .OSC_TICK(osc_tick), .POWER_FAIL(power_fail), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .SHARED_INTERRUPT_OUTPUT_O(pin_o), .SHARED_INTERRUPT_OUTPUT_OE_N(pin_oe_n), .TIMER_EXPIRY_FLAG(flag));
    rcdt_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq_line_n(irq_n));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // bounded wait for the pin level, sampled mid-cycle where it has settled
    task automatic wait_pin(input logic lvl, output int t);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (irq_n === lvl) begin
                t = cyc;
                return;
            end
        end
        chk("pin wait", 16'(irq_n), 16'(lvl));
        complete_run();
    endtask : wait_pin
    // park on the slowest source while idle, clear the flag, then load
    task automatic setup(input logic [7:0] n, input logic [7:0] c);
        logic [7:0] d;
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h03);
        host_u.rd(rcdt_pkg::ADDR_FLAGS, d);
        host_u.wr(rcdt_pkg::ADDR_VALUE, n);
        host_u.wr(rcdt_pkg::ADDR_CTRL, c);
    endtask : setup
    initial begin
        logic [7:0] d;
        logic [7:0] h;
        int t0, t1, t2;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        host_u.rd(rcdt_pkg::ADDR_CTRL, d);
        chk("ctrl reset", 16'(d), 16'h0003);
        host_u.rd(rcdt_pkg::ADDR_VALUE, d);
        chk("value reset", 16'(d), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(rcdt_pkg::ADDR_CTRL, 8'(i));
            host_u.rd(rcdt_pkg::ADDR_CTRL, d);
            chk("select", 16'(d), 16'(i));
        end
        host_u.wr(8'h20, 8'hff);
        host_u.rd(8'h20, d);
        chk("unmapped", 16'(d), 16'h0000);
        setup(8'h00, 8'ha0);
        repeat (200) @(posedge clk);
        chk("zero reload", 16'(flag), 16'h0000);
        // level mode, reload two at the fastest source
        setup(8'h02, 8'ha0);
        wait_pin(1'b0, t0);
        chk("level flag", 16'(flag), 16'h0001);
        host_u.rd(rcdt_pkg::ADDR_FLAGS, d);
        chk("flag bit", 16'(d[rcdt_pkg::FLAG_EXPIRY_BIT]), 16'h0001);
        @(negedge clk);
        chk("read clear", 16'({flag, irq_n}), 16'h0001);
        wait_pin(1'b0, t1);
        chk("level period", 16'(t1 - t0), 16'd32);
        host_u.wr(rcdt_pkg::ADDR_VALUE, 8'h02);
        @(negedge clk);
        chk("value write", 16'({flag, irq_n}), 16'h0002);
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h80);
        @(negedge clk);
        chk("enable off", 16'({flag, irq_n}), 16'h0003);
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h00);
        host_u.wr(rcdt_pkg::ADDR_VALUE, 8'h40);
        host_u.rd(rcdt_pkg::ADDR_FLAGS, d);
        repeat (100) @(posedge clk);
        host_u.rd(rcdt_pkg::ADDR_VALUE, d);
        chk("halted", 16'({flag, d}), 16'h0040);
        // run about twenty source ticks, then stop and hold
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h80);
        repeat (320) @(posedge clk);
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h00);
        host_u.rd(rcdt_pkg::ADDR_VALUE, h);
        chk("counted", 16'(h < 8'h40 && h > 8'h20), 16'h0001);
        repeat (100) @(posedge clk);
        host_u.rd(rcdt_pkg::ADDR_VALUE, d);
        chk("held count", 16'(d), 16'(h));
        // at most one tick can pass before the read is taken
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h80);
        host_u.rd(rcdt_pkg::ADDR_VALUE, d);
        chk("resume", 16'((d == h) || (d == h - 8'h01)), 16'h0001);
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'ha0);
        @(posedge clk);
        power_fail <= 1'b1;
        @(posedge clk);
        power_fail <= 1'b0;
        host_u.rd(rcdt_pkg::ADDR_CTRL, d);
        chk("power loss", 16'(d), 16'h0020);
        // pulse mode, flag read between pulses yet pulses must continue
        for (int i = 0; i < 4; i++) begin
            setup(tn[i], tc[i]);
            wait_pin(1'b0, t0);
            wait_pin(1'b1, t1);
            host_u.rd(rcdt_pkg::ADDR_FLAGS, d);
            wait_pin(1'b0, t2);
            chk("pulse flag", 16'(d[rcdt_pkg::FLAG_EXPIRY_BIT]), 16'h0001);
            chk("pulse width", 16'(t1 - t0), tw[i]);
            chk("pulse period", 16'(t2 - t0), tp[i]);
        end
        // pin is mid-pulse here; dropping run must end it at once
        host_u.wr(rcdt_pkg::ADDR_CTRL, 8'h61);
        @(negedge clk);
        chk("pulse stop", 16'(irq_n), 16'h0001);
        complete_run();
    end
endmodule : rcdt_timer_tb
